// file: common/fapes_cfg.svh
// Constants of the flash program and erase controller
`ifndef FAPES_CFG_SVH
`define FAPES_CFG_SVH

// Clock rate
`define FAPES_CLK_MHZ 20

// Register byte offsets
`define FAPES_REG_CTRL 8'h00
`define FAPES_REG_ADDR 8'h04
`define FAPES_REG_DATA 8'h08
`define FAPES_REG_STATUS 8'h0C
`define FAPES_REG_IRQ_STAT 8'h10
`define FAPES_REG_IRQ_CLR 8'h14
`define FAPES_REG_IRQ_EN 8'h18

// Control fields
`define FAPES_CTRL_START 0
`define FAPES_CTRL_OP_LO 1
`define FAPES_CTRL_OP_HI 3

// Interrupt bits
`define FAPES_IRQ_DONE 0
`define FAPES_IRQ_FAIL 1
`define FAPES_IRQ_TMO 2

// Status bit positions inside a status read
`define FAPES_DQ_POLL 7
`define FAPES_DQ_TOGGLE 6
`define FAPES_DQ_TLIMIT 5
`define FAPES_DQ_EWIN 3

// Sector select address bits
`define FAPES_SECT_LO 12
`define FAPES_SECT_HI 18

// Command sequence words
`define FAPES_UNLK1_ADDR 19'h0_0555
`define FAPES_UNLK2_ADDR 19'h0_02AA
`define FAPES_UNLK1_DATA 16'h00AA
`define FAPES_UNLK2_DATA 16'h0055
`define FAPES_CMD_PROG 16'h00A0
`define FAPES_CMD_ERASE 16'h0080
`define FAPES_CMD_CHIP 16'h0010
`define FAPES_CMD_SECT 16'h0030

// Bus timing in ns and derived cycles (least times round up)
`define FAPES_WE_LOW_NS 55
`define FAPES_ACC_NS 120
`define FAPES_WE_CYC ((`FAPES_WE_LOW_NS*`FAPES_CLK_MHZ+999)/1000)
`define FAPES_RD_CYC ((`FAPES_ACC_NS*`FAPES_CLK_MHZ+999)/1000)

// Protect pulse widths and algorithm limits
`define FAPES_PROT_US 10
`define FAPES_UNPROT_MS 12
`define FAPES_PROG_MAX_US 360
`define FAPES_SECT_MAX_S 12
`define FAPES_CHIP_MAX_S 64
`define FAPES_LOAD_US 100
`define FAPES_PROT_CYC (`FAPES_PROT_US*`FAPES_CLK_MHZ)
`define FAPES_UNPROT_CYC (`FAPES_UNPROT_MS*1000*`FAPES_CLK_MHZ)
`define FAPES_PROG_TMO (`FAPES_PROG_MAX_US*`FAPES_CLK_MHZ)
`define FAPES_SECT_TMO (`FAPES_SECT_MAX_S*1000000*`FAPES_CLK_MHZ)
`define FAPES_CHIP_TMO (`FAPES_CHIP_MAX_S*1000000*`FAPES_CLK_MHZ)

`endif

// file: common/fapes_pkg.sv
// Types of the flash program and erase controller
package fapes_pkg;

  typedef enum logic [2:0] {
    OP_PROG, OP_CHIP, OP_SECT, OP_PROT, OP_UNPROT, OP_READ
  } fapes_op_e;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WSET, ST_WLOW, ST_WHOLD, ST_WGAP,
    ST_RSET, ST_RWAIT, ST_EVAL, ST_PULSE, ST_DONE
  } fapes_state_e;

  typedef struct packed {
    logic reset_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [18:0] addr;
    logic [15:0] dout;
  } fapes_pins_s;

  typedef struct packed {
    fapes_state_e state;
    fapes_op_e op;
    logic [2:0] idx;
    logic [31:0] cnt;
    logic [31:0] tmo;
    logic [18:0] addr;
    logic [15:0] data;
    logic [15:0] prev;
    logic [15:0] last;
    logic first;
    logic recheck;
    logic busy;
    logic ok;
    logic fail;
    logic tmo_hit;
    logic [2:0] irq;
    logic [2:0] irq_en;
    logic [31:0] rdata;
    logic [15:0] sync1;
    logic [15:0] sync2;
    fapes_pins_s pins;
  } fapes_st_s;

endpackage

// file: hdl/fapes_ctrl.sv
// Host controller driving a parallel flash through program and erase
`timescale 1ns/1ps
`default_nettype none
`include "fapes_cfg.svh"

module fapes_ctrl #(
  parameter logic [31:0] PROG_TMO_CYC = 32'(`FAPES_PROG_TMO),
  parameter logic [31:0] SECT_TMO_CYC = 32'(`FAPES_SECT_TMO),
  parameter logic [31:0] CHIP_TMO_CYC = 32'(`FAPES_CHIP_TMO),
  parameter logic [31:0] UNPROT_CYC = 32'(`FAPES_UNPROT_CYC)
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Interrupt
  output logic IRQ,
  // Flash pins
  output fapes_pkg::fapes_pins_s FL_PINS,
  input wire logic [15:0] FL_DQ_IN
);
  import fapes_pkg::*;

  localparam fapes_pins_s PINS_RST = '{
    reset_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
    dq_oe_n: 1'b1, addr: 19'h0_0000, dout: 16'h0000};

  fapes_st_s s_q;
  fapes_st_s s_d;

  function automatic logic [2:0] seq_last(input fapes_op_e op);
    seq_last = (op == OP_PROG) ? 3'h3 : 3'h5;
  endfunction

  function automatic logic [34:0] seq_word(input fapes_op_e op,
                                           input logic [2:0] idx,
                                           input logic [18:0] addr,
                                           input logic [15:0] data);
    logic [18:0] sect;
    sect = {addr[`FAPES_SECT_HI:`FAPES_SECT_LO], 12'h000};
    case (idx)
      3'h0: seq_word = {`FAPES_UNLK1_ADDR, `FAPES_UNLK1_DATA};
      3'h1: seq_word = {`FAPES_UNLK2_ADDR, `FAPES_UNLK2_DATA};
      3'h2: seq_word = {`FAPES_UNLK1_ADDR,
                        (op == OP_PROG) ? `FAPES_CMD_PROG : `FAPES_CMD_ERASE};
      3'h3: seq_word = (op == OP_PROG) ? {addr, data}
                       : {`FAPES_UNLK1_ADDR, `FAPES_UNLK1_DATA};
      3'h4: seq_word = {`FAPES_UNLK2_ADDR, `FAPES_UNLK2_DATA};
      3'h5: seq_word = (op == OP_SECT) ? {sect, `FAPES_CMD_SECT}
                       : {`FAPES_UNLK1_ADDR, `FAPES_CMD_CHIP};
      default: seq_word = {`FAPES_UNLK1_ADDR, `FAPES_UNLK1_DATA};
    endcase
  endfunction

  function automatic logic [31:0] tmo_of(input fapes_op_e op);
    case (op)
      OP_PROG: tmo_of = PROG_TMO_CYC;
      OP_SECT: tmo_of = SECT_TMO_CYC;
      OP_CHIP: tmo_of = CHIP_TMO_CYC;
      default: tmo_of = PROG_TMO_CYC;
    endcase
  endfunction

  always_comb
  begin
    logic [2:0] set;
    logic [2:0] clr;
    logic [34:0] word;
    logic expect7;
    set = 3'h0;
    clr = 3'h0;
    word = seq_word(s_q.op, s_q.idx, s_q.addr, s_q.data);
    expect7 = (s_q.op == OP_PROG) ? s_q.data[`FAPES_DQ_POLL] : 1'b1;
    s_d = s_q;
    s_d.sync1 = FL_DQ_IN;
    s_d.sync2 = s_q.sync1;
    s_d.pins.reset_n = 1'b1;
    s_d.rdata = 32'h0000_0000;
    if (s_q.tmo != 32'h0000_0000)
    begin
      s_d.tmo = s_q.tmo - 32'h0000_0001;
    end

    if (REG_RD)
    begin
      case (REG_ADDR)
        `FAPES_REG_CTRL: s_d.rdata = {28'h000_0000, s_q.op, 1'b0};
        `FAPES_REG_ADDR: s_d.rdata = {13'h0000, s_q.addr};
        `FAPES_REG_DATA: s_d.rdata = {16'h0000, s_q.data};
        `FAPES_REG_STATUS: s_d.rdata = {s_q.last, 12'h000, s_q.tmo_hit,
                                        s_q.fail, s_q.ok, s_q.busy};
        `FAPES_REG_IRQ_STAT: s_d.rdata = {29'h0000_0000, s_q.irq};
        `FAPES_REG_IRQ_EN: s_d.rdata = {29'h0000_0000, s_q.irq_en};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    if (REG_WR)
    begin
      case (REG_ADDR)
        `FAPES_REG_ADDR:
        begin
          if (!s_q.busy)
          begin
            s_d.addr = REG_WDATA[18:0];
          end
        end
        `FAPES_REG_DATA:
        begin
          if (!s_q.busy)
          begin
            s_d.data = REG_WDATA[15:0];
          end
        end
        `FAPES_REG_IRQ_CLR: clr = REG_WDATA[2:0];
        `FAPES_REG_IRQ_EN: s_d.irq_en = REG_WDATA[2:0];
        default: ;
      endcase
    end

    case (s_q.state)
      ST_IDLE:
      begin
        // Orders arriving while busy are dropped, not queued
        if (REG_WR && REG_ADDR == `FAPES_REG_CTRL &&
            REG_WDATA[`FAPES_CTRL_START])
        begin
          s_d.op = fapes_op_e'(REG_WDATA[`FAPES_CTRL_OP_HI:`FAPES_CTRL_OP_LO]);
          s_d.busy = 1'b1;
          s_d.ok = 1'b0;
          s_d.fail = 1'b0;
          s_d.tmo_hit = 1'b0;
          s_d.idx = 3'h0;
          s_d.first = 1'b1;
          s_d.recheck = 1'b0;
          case (s_d.op)
            OP_PROT:
            begin
              s_d.pins.ce_n = 1'b0;
              s_d.pins.we_n = 1'b0;
              s_d.cnt = 32'(`FAPES_PROT_CYC - 1);
              s_d.state = ST_PULSE;
            end
            OP_UNPROT:
            begin
              s_d.pins.ce_n = 1'b0;
              s_d.pins.we_n = 1'b0;
              s_d.cnt = UNPROT_CYC - 32'h0000_0001;
              s_d.state = ST_PULSE;
            end
            OP_READ: s_d.state = ST_RSET;
            default: s_d.state = (s_d.op > OP_READ) ? ST_DONE : ST_WSET;
          endcase
        end
      end
      ST_WSET:
      begin
        s_d.pins.addr = word[34:16];
        s_d.pins.dout = word[15:0];
        s_d.pins.ce_n = 1'b0;
        s_d.pins.dq_oe_n = 1'b0;
        s_d.pins.we_n = 1'b0;
        s_d.cnt = 32'(`FAPES_WE_CYC - 1);
        s_d.state = ST_WLOW;
      end
      ST_WLOW, ST_PULSE:
      begin
        if (s_q.cnt == 32'h0000_0000)
        begin
          s_d.pins.we_n = 1'b1;
          s_d.state = ST_WHOLD;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
      end
      ST_WHOLD:
      begin
        // Address and data held one cycle past the write strobe edge
        s_d.pins.ce_n = 1'b1;
        s_d.state = ST_WGAP;
      end
      ST_WGAP:
      begin
        s_d.pins.dq_oe_n = 1'b1;
        if (s_q.op == OP_PROT || s_q.op == OP_UNPROT)
        begin
          s_d.ok = 1'b1;
          s_d.state = ST_DONE;
        end
        else if (s_q.idx == seq_last(s_q.op))
        begin
          s_d.tmo = tmo_of(s_q.op);
          s_d.state = ST_RSET;
        end
        else
        begin
          s_d.idx = s_q.idx + 3'h1;
          s_d.state = ST_WSET;
        end
      end
      ST_RSET:
      begin
        // status read at the operation address
        s_d.pins.addr = s_q.addr;
        s_d.pins.ce_n = 1'b0;
        s_d.pins.oe_n = 1'b0;
        // Access time plus the two-stage input synchroniser
        s_d.cnt = 32'(`FAPES_RD_CYC + 1);
        s_d.state = ST_RWAIT;
      end
      ST_RWAIT:
      begin
        if (s_q.cnt == 32'h0000_0000)
        begin
          // keep the erase window flag readable
          s_d.last = s_q.sync2;
          s_d.pins.ce_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.state = ST_EVAL;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
      end
      ST_EVAL:
      begin
        // One idle cycle here also lets the flash float its outputs
        if (s_q.op == OP_READ)
        begin
          s_d.ok = 1'b1;
          s_d.state = ST_DONE;
        end
        else if (s_q.first)
        begin
          s_d.prev = s_q.last;
          s_d.first = 1'b0;
          s_d.state = ST_RSET;
        end
        else if (s_q.prev[`FAPES_DQ_TOGGLE] == s_q.last[`FAPES_DQ_TOGGLE])
        begin
          s_d.ok = (s_q.last[`FAPES_DQ_POLL] == expect7);
          s_d.fail = (s_q.last[`FAPES_DQ_POLL] != expect7);
          s_d.state = ST_DONE;
        end
        else if (s_q.recheck)
        begin
          s_d.fail = 1'b1;
          s_d.state = ST_DONE;
        end
        else if (s_q.tmo == 32'h0000_0000)
        begin
          s_d.tmo_hit = 1'b1;
          s_d.state = ST_DONE;
        end
        else
        begin
          s_d.prev = s_q.last;
          s_d.recheck = s_q.last[`FAPES_DQ_TLIMIT];
          s_d.state = ST_RSET;
        end
      end
      ST_DONE:
      begin
        s_d.busy = 1'b0;
        set[`FAPES_IRQ_DONE] = 1'b1;
        set[`FAPES_IRQ_FAIL] = s_q.fail;
        set[`FAPES_IRQ_TMO] = s_q.tmo_hit;
        s_d.state = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase

    // A new event wins over a clear in the same cycle
    s_d.irq = (s_q.irq & ~clr) | set;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      s_q <= '0;
      s_q.pins <= PINS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA = s_q.rdata;
  assign IRQ = |(s_q.irq & s_q.irq_en);
  assign FL_PINS = s_q.pins;

endmodule // fapes_ctrl

`default_nettype wire

// file: test/fapes_ctrl_assertions.sv
// Port checker for the flash program and erase controller
`timescale 1ns/1ps
`default_nettype none
`include "fapes_cfg.svh"
module fapes_ctrl_assertions #(
  parameter logic [31:0] UNPROT_CYC = 32'h0003_A980
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Register read side
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Flash pins
  input wire fapes_pkg::fapes_pins_s FL_PINS
);
  import fapes_pkg::*;
  logic [31:0] low_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // Length of the running write strobe
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN || FL_PINS.we_n)
      low_q <= 32'h0000_0000;
    else
      low_q <= low_q + 32'h0000_0001;
  end
  a_we_width: assert property ($rose(FL_PINS.we_n) |->
    low_q == `FAPES_WE_CYC || low_q == `FAPES_PROT_CYC || low_q == UNPROT_CYC)
    else $error("write strobe width off");
  a_no_contend: assert property (!FL_PINS.oe_n |->
    FL_PINS.dq_oe_n && FL_PINS.we_n) else $error("bus contention");
  a_strobe_ce: assert property (!FL_PINS.oe_n || !FL_PINS.we_n |->
    !FL_PINS.ce_n) else $error("strobe without chip enable");
  a_write_hold: assert property ($fell(FL_PINS.we_n) |=>
    $stable(FL_PINS.addr) && !FL_PINS.ce_n) else $error("address moved");
  a_read_len: assert property ($fell(FL_PINS.oe_n) |->
    !FL_PINS.oe_n [*5] ##1 FL_PINS.oe_n) else $error("status read length");
  a_read_gap: assert property ($rose(FL_PINS.oe_n) |->
    FL_PINS.oe_n [*2]) else $error("status reads too close");
  a_rdata_zero: assert property (!$past(REG_RD) |->
    REG_RDATA == 32'h0000_0000) else $error("read data outside slot");
  a_flash_rst: assert property ($past(RESETN) |-> FL_PINS.reset_n)
    else $error("flash held in reset");
endmodule // fapes_ctrl_assertions
bind fapes_ctrl fapes_ctrl_assertions #(.UNPROT_CYC(UNPROT_CYC)) u_chk (
  .CLOCK(CLOCK), .RESETN(RESETN), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .FL_PINS(FL_PINS));
`default_nettype wire

// file: test/fapes_flash_model.sv
// Behavioural parallel flash with self-timed program and erase
`timescale 1ns/1ps
`default_nettype none
`include "fapes_cfg.svh"
module fapes_flash_model #(
  // Sector load window in clock cycles
  parameter int LOAD_CYC = `FAPES_LOAD_US * `FAPES_CLK_MHZ
) (
  // Pins
  input wire logic clock,
  input wire fapes_pkg::fapes_pins_s pins,
  output logic [15:0] dq,
  // Bench control and view
  input wire logic [1:0] mode,
  input wire logic [7:0] busy_cyc,
  output int n_cmd,
  output int kind,
  output logic [6:0] sect,
  output logic [15:0] mem,
  output int wlen
);
  import fapes_pkg::*;
  logic [18:0] wa [6];
  logic [15:0] wd [6];
  logic [15:0] tgt;
  logic we_q, oe_q, tog, ers, prg, era;
  int bcnt, run, wcnt;
  function automatic logic hit(int i, logic [18:0] ad, logic [15:0] dv);
    return wa[i] === ad && wd[i] === dv;
  endfunction
  function automatic logic unl(int i);
    return hit(i + 1, `FAPES_UNLK1_ADDR, `FAPES_UNLK1_DATA) &&
      hit(i, `FAPES_UNLK2_ADDR, `FAPES_UNLK2_DATA);
  endfunction
  initial
  begin
    {dq, n_cmd, kind, bcnt, run, wcnt, tog, ers} = '0;
    mem = 16'hFFFF;
  end
  always @(posedge clock)
  begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    run <= (!pins.we_n && !pins.ce_n) ? run + 1 : 0;
    if (pins.we_n && !we_q)
      wlen <= run;
    // sector erase waits out the sector load window
    if (wcnt > 0)
      wcnt <= wcnt - 1;
    if (pins.we_n && !we_q && !pins.ce_n && bcnt == 0)
    begin
      for (int i = 5; i > 0; i--)
      begin
        wa[i] <= wa[i-1];
        wd[i] <= wd[i-1];
      end
      wa[0] <= pins.addr;
      wd[0] <= pins.dout;
      prg = unl(1) && hit(0, `FAPES_UNLK1_ADDR, `FAPES_CMD_PROG);
      era = unl(3) && hit(2, `FAPES_UNLK1_ADDR, `FAPES_CMD_ERASE) && unl(0)
        && (pins.dout == `FAPES_CMD_CHIP || pins.dout == `FAPES_CMD_SECT);
      if (prg || era)
      begin
        bcnt <= busy_cyc;
        n_cmd <= n_cmd + 1;
        ers <= era;
        wcnt <= (era && pins.dout == `FAPES_CMD_SECT) ? LOAD_CYC : 0;
        kind <= prg ? 0 : (pins.dout == `FAPES_CMD_CHIP ? 1 : 2);
        sect <= pins.addr[18:12];
        tgt <= pins.dout;
        mem <= prg ? mem & pins.dout : 16'hFFFF;
      end
    end
    if (bcnt > 0 && mode == 2'h0 && wcnt == 0)
      bcnt <= bcnt - 1;
    if (pins.oe_n && !oe_q && bcnt > 0)
      tog <= ~tog;
    if (!pins.ce_n && !pins.oe_n)
      dq <= bcnt == 0 ? mem : {8'h00, ~ers & ~tgt[7], tog, mode == 2'h1,
        1'b0, ers && wcnt == 0, 3'h0};
    else
      dq <= ~dq;
  end
endmodule // fapes_flash_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the flash program and erase controller
`timescale 1ns/1ps
`default_nettype none
`include "fapes_cfg.svh"
module testbench;
  import fapes_pkg::*;
  localparam logic [31:0] UNPROT = 32'h0000_0032;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0000_0000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA, s, a, d;
  logic IRQ;
  fapes_pins_s FL_PINS;
  logic [15:0] FL_DQ_IN, mem;
  logic [15:0] exp_mem = 16'hFFFF;
  logic [1:0] mode = 2'h0;
  logic [7:0] busy_cyc = 8'h10;
  logic [6:0] sect;
  logic [2:0] ops [6] = '{3'h1, 3'h2, 3'h0, 3'h5, 3'h3, 3'h4};
  int n_errors = 0, n_tests = 0, seed = 62, exp_cmd = 0, n_cmd, kind, wlen;
  always #25 CLOCK = ~CLOCK;
  fapes_ctrl #(.PROG_TMO_CYC(32'h0000_00C8), .SECT_TMO_CYC(32'h0000_012C),
    .CHIP_TMO_CYC(32'h0000_012C), .UNPROT_CYC(UNPROT)) dut (
    .CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .IRQ(IRQ), .FL_PINS(FL_PINS), .FL_DQ_IN(FL_DQ_IN));
  fapes_flash_model #(.LOAD_CYC(4)) u_flash (.clock(CLOCK), .pins(FL_PINS),
    .dq(FL_DQ_IN),
    .mode(mode), .busy_cyc(busy_cyc), .n_cmd(n_cmd), .kind(kind),
    .sect(sect), .mem(mem), .wlen(wlen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wv);
    @(posedge CLOCK);
    REG_ADDR <= ad;
    REG_WDATA <= wv;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
    @(posedge CLOCK);
    REG_ADDR <= ad;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    @(negedge CLOCK);
    rv = REG_RDATA;
  endtask
  // Start an operation and poll until busy drops, bounded
  task automatic run_op(input logic [2:0] op);
    wr(`FAPES_REG_CTRL, {28'h000_0000, op, 1'b1});
    s = 32'h0000_0001;
    for (int i = 0; i < 2000 && s[0] !== 1'b0; i++)
      rd(`FAPES_REG_STATUS, s);
    if (s[0] !== 1'b0)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic irq_chk(input int b);
    rd(`FAPES_REG_IRQ_STAT, s);
    chk(32'(s[b]), 32'h0000_0001);
    chk(32'(IRQ), 32'h0000_0001);
    wr(`FAPES_REG_IRQ_EN, 32'h0000_0000);
    repeat (2) @(negedge CLOCK);
    chk(32'(IRQ), 32'h0000_0000);
    wr(`FAPES_REG_IRQ_CLR, 32'h0000_0007);
    rd(`FAPES_REG_IRQ_STAT, s);
    chk(s, 32'h0000_0000);
    wr(`FAPES_REG_IRQ_EN, 32'h0000_0007);
  endtask
  initial
  begin
    repeat (5) @(posedge CLOCK);
    RESETN <= 1'b1;
    rd(`FAPES_REG_STATUS, s);
    chk(s, 32'h0000_0000);
    rd(8'h1C, s);
    chk(s, 32'h0000_0000);
    wr(`FAPES_REG_IRQ_EN, 32'h0000_0007);
    foreach (ops[k])
    begin
      a = 32'($random(seed)) & 32'h0007_FFFF;
      d = 32'($random(seed)) & 32'h0000_FFFF;
      busy_cyc <= 8'h08 + 8'($random(seed) & 63);
      wr(`FAPES_REG_ADDR, a);
      wr(`FAPES_REG_DATA, d);
      run_op(ops[k]);
      // Flash bits only clear on program; erase sets all ones
      exp_mem = ops[k] == 3'h0 ? exp_mem & d[15:0] :
        (ops[k] < 3'h3 ? 16'hFFFF : exp_mem);
      exp_cmd += int'(ops[k] < 3'h3);
      if (ops[k] < 3'h3)
        chk(32'(kind), 32'(ops[k]));
      if (ops[k] == 3'h2)
        chk(32'(sect), 32'(a[18:12]));
      if (ops[k] == 3'h3 || ops[k] == 3'h4)
        chk(32'(wlen), ops[k] == 3'h3 ? `FAPES_PROT_CYC : UNPROT);
      else
        chk({s[31:16], 12'h000, s[3:0]}, {exp_mem, 16'h0002});
      chk(32'(n_cmd), 32'(exp_cmd));
      irq_chk(0);
    end
    // An undefined operation code finishes at once and issues nothing
    run_op(3'h6);
    chk(32'(s[3:0]), 32'h0000_0000);
    chk(32'(n_cmd), 32'(exp_cmd));
    irq_chk(0);
    mode <= 2'h1;
    run_op(3'h0);
    chk(32'(s[3:0]), 32'h0000_0004);
    irq_chk(1);
    mode <= 2'h2;
    run_op(3'h0);
    chk(32'(s[3:0]), 32'h0000_0008);
    irq_chk(2);
    // Reset while idle after the last run: flash held in reset, enables back to zero
    @(posedge CLOCK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(negedge CLOCK);
    chk(32'(FL_PINS.reset_n), 32'h0000_0000);
    rd(`FAPES_REG_IRQ_EN, s);
    chk(s, 32'h0000_0000);
    chk(32'(FL_PINS.reset_n), 32'h0000_0001);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
